// [hdl/cpw_top.sv]
`timescale 1ns/100ps
// ==========================================
// Wakeup and transmit-complete waits
// ==========================================
module cpw_top (
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic START_COMM, // Start communication pulse
    input wire logic STOP_COMM, // Stop communication pulse
    input wire logic XCVR_SLEEP_IN, // Transceiver asleep, from outside
    input wire logic MODE_WR_NORMAL, // Caller writes mode Normal, pulse
    input wire logic TX_QUEUED, // Frame queued, pulse
    input wire logic TX_FINISHED, // Frame sent or aborted, pulse
    input wire logic WAKE_REQ, // Wakeup wait request pulse
    input wire logic [cpw_pkg::TMO_W-1:0] WAKE_TIMEOUT, // Wakeup timeout, ms
    input wire logic TXC_REQ, // Transmit wait request pulse
    input wire logic [cpw_pkg::TMO_W-1:0] TXC_TIMEOUT, // Transmit timeout, ms
    output logic WAKE_DONE, // Wakeup wait result pulse
    output logic WAKE_TIMED_OUT, // Wakeup timed-out flag
    output logic WAKE_ERROR, // Wakeup error, stopped
    output logic TXC_DONE, // Transmit wait result pulse
    output logic TXC_TIMED_OUT, // Transmit timed-out flag
    output logic TXC_ERROR, // Transmit error, stopped
    output logic COMM_RUNNING, // Communication started
    output logic TX_ALL_DONE // No frames pending
);
    import cpw_pkg::*;
    // ==========================================
    // Pin synchroniser and mode edge
    // ==========================================
    logic sleep_s1_reg, sleep_s2_reg, sleep_d_reg; // Two flops plus history
    logic run_reg; // Communication running
    logic remote_wake; // Sleep to normal on the pin
    logic wake_evt; // Any wakeup while running
    assign remote_wake = sleep_d_reg && !sleep_s2_reg;
    // Only the caller's write from Sleep counts as a local wakeup
    assign wake_evt = run_reg && (remote_wake || (MODE_WR_NORMAL && sleep_s2_reg));
    // Synchroniser
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            sleep_s1_reg <= 1'b0;
            sleep_s2_reg <= 1'b0;
            sleep_d_reg <= 1'b0;
        end else begin
            sleep_s1_reg <= XCVR_SLEEP_IN;
            sleep_s2_reg <= sleep_s1_reg;
            sleep_d_reg <= sleep_s2_reg;
        end
    end
    // ==========================================
    // Run state, wake latch, pending count
    // ==========================================
    logic latch_reg, latch_next; // Wakeup since last wait
    logic [PEND_W-1:0] pend_reg, pend_next; // Frames in flight
    logic wake_consume; // Wakeup wait completes on event
    logic txc_hit; // Transmit condition met
    assign txc_hit = (pend_reg == PEND_RESET);
    assign TX_ALL_DONE = txc_hit;
    assign COMM_RUNNING = run_reg;
    // A wakeup that ends a busy wait is used up there, so it cannot also satisfy the next wait
    // Stop clears first, so nothing is recorded once stopped; start clears without setting
    assign latch_next = (STOP_COMM || wake_consume) ? 1'b0 :
        (wake_evt ? 1'b1 : (START_COMM ? 1'b0 : latch_reg));
    // Queue count; stop or start empties it, a lone finish on empty is ignored
    always_comb begin
        pend_next = pend_reg;
        if (STOP_COMM || START_COMM) begin
            pend_next = PEND_RESET;
        end else if (run_reg && TX_QUEUED && !TX_FINISHED) begin
            pend_next = (pend_reg == 8'hff) ? pend_reg : pend_reg + 8'h01;
        end else if (TX_FINISHED && !TX_QUEUED && pend_reg != PEND_RESET) begin
            pend_next = pend_reg - 8'h01;
        end
    end
    // Run, latch and count registers
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            run_reg <= 1'b0;
            latch_reg <= 1'b0;
            pend_reg <= PEND_RESET;
        end else begin
            run_reg <= STOP_COMM ? 1'b0 : (START_COMM ? 1'b1 : run_reg);
            latch_reg <= latch_next;
            pend_reg <= pend_next;
        end
    end
    // ==========================================
    // Millisecond tick
    // ==========================================
    localparam logic [31:0] TICK_LAST = 32'(TICK_CYCLES - 1);
    logic [31:0] div_reg; // Tick divider
    logic tick; // One-cycle tick
    assign tick = (div_reg == TICK_LAST);
    // Divider runs freely; first tick comes up to one ms early
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            div_reg <= 32'h0000_0000;
        end else begin
            div_reg <= tick ? 32'h0000_0000 : div_reg + 32'h0000_0001;
        end
    end
    // ==========================================
    // Wait engines
    // ==========================================
    cpw_wait_if wk_if ();
    cpw_wait_if tx_if ();
    logic wake_err_req, txc_err_req; // Request made while stopped
    assign wake_err_req = WAKE_REQ && !run_reg && !wk_if.busy;
    assign txc_err_req = TXC_REQ && !run_reg && !tx_if.busy;
    assign wk_if.start = WAKE_REQ && run_reg;
    assign wk_if.timeout = WAKE_TIMEOUT;
    assign wk_if.event_hit = latch_reg || wake_evt;
    assign wk_if.abort = STOP_COMM;
    assign wk_if.tick = tick;
    assign tx_if.start = TXC_REQ && run_reg;
    assign tx_if.timeout = TXC_TIMEOUT;
    assign tx_if.event_hit = txc_hit;
    assign tx_if.abort = STOP_COMM;
    assign tx_if.tick = tick;
    assign wake_consume = wk_if.busy && wk_if.event_hit && !STOP_COMM;
    cpw_wait_engine u_wake (
        .clk(CLK),
        .rst_n(RST_N),
        .w(wk_if)
    );
    cpw_wait_engine u_txc (
        .clk(CLK),
        .rst_n(RST_N),
        .w(tx_if)
    );
    // ==========================================
    // Result registers
    // ==========================================
    // Error result is a one-cycle done with error set, not timed out
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            WAKE_DONE <= 1'b0;
            WAKE_TIMED_OUT <= 1'b0;
            WAKE_ERROR <= 1'b0;
            TXC_DONE <= 1'b0;
            TXC_TIMED_OUT <= 1'b0;
            TXC_ERROR <= 1'b0;
        end else begin
            WAKE_DONE <= wk_if.done || wake_err_req;
            WAKE_TIMED_OUT <= wk_if.done && wk_if.timed_out;
            WAKE_ERROR <= wake_err_req;
            TXC_DONE <= tx_if.done || txc_err_req;
            TXC_TIMED_OUT <= tx_if.done && tx_if.timed_out;
            TXC_ERROR <= txc_err_req;
        end
    end
    // ==========================================
    // Checks
    // ==========================================
    a_stop_error: assert property (@(posedge CLK) disable iff (!RST_N)
        (WAKE_REQ && !run_reg && !wk_if.busy) |=> (WAKE_DONE && WAKE_ERROR && !WAKE_TIMED_OUT))
        else $error("stopped wakeup wait gave no error");
    a_txc_stop_error: assert property (@(posedge CLK) disable iff (!RST_N)
        (TXC_REQ && !run_reg && !tx_if.busy) |=> (TXC_DONE && TXC_ERROR))
        else $error("stopped transmit wait gave no error");
    a_tmo_no_err: assert property (@(posedge CLK) disable iff (!RST_N)
        (WAKE_TIMED_OUT || TXC_TIMED_OUT) |-> !(WAKE_TIMED_OUT && WAKE_ERROR) && !(TXC_TIMED_OUT && TXC_ERROR))
        else $error("timeout reported as error");
    a_start_empty: assert property (@(posedge CLK) disable iff (!RST_N)
        START_COMM |=> TX_ALL_DONE)
        else $error("start left frames pending");
    a_start_no_wake: assert property (@(posedge CLK) disable iff (!RST_N)
        (START_COMM && !wake_evt) |=> !latch_reg)
        else $error("start set the wake latch");
    a_stopped_no_latch: assert property (@(posedge CLK) disable iff (!RST_N)
        (!run_reg && !latch_reg) |=> !latch_reg)
        else $error("wakeup recorded while stopped");
    a_latch_fast: assert property (@(posedge CLK) disable iff (!RST_N)
        (latch_reg && run_reg && WAKE_REQ && !STOP_COMM && !wk_if.busy && !wk_if.done)
        |=> (STOP_COMM or ##2 (WAKE_DONE && !WAKE_TIMED_OUT)))
        else $error("latched wakeup did not return at once");
    a_txc_pending: assert property (@(posedge CLK) disable iff (!RST_N)
        (TXC_DONE && TXC_TIMED_OUT) |-> $past(pend_reg, 2) != PEND_RESET)
        else $error("transmit timed out with nothing pending");
    a_local_wake: assert property (@(posedge CLK) disable iff (!RST_N)
        (run_reg && MODE_WR_NORMAL && sleep_s2_reg && !STOP_COMM) |=> latch_reg || $past(wake_consume))
        else $error("local wakeup not latched");
    c_wake_ok: cover property (@(posedge CLK) disable iff (!RST_N) WAKE_DONE && !WAKE_TIMED_OUT && !WAKE_ERROR);
    c_txc_tmo: cover property (@(posedge CLK) disable iff (!RST_N) TXC_DONE && TXC_TIMED_OUT);
    c_err: cover property (@(posedge CLK) disable iff (!RST_N) TXC_ERROR);
endmodule

// [hdl/cpw_pkg.sv]
// Notes on behaviour
// - Wakeup wait ends on sleep-to-normal change
// - Caller write of normal mode from sleep wakes locally
// - Wakeup since last wait is latched
// - Start sets no latch; stopped records nothing
// - Both waits error while communication stopped
// - Millisecond timeout; zero polls wakeup latch once
// - Timeout minus one waits without limit
// - Timeout sets flag, error stays clear
// - Transmit wait needs every queued frame finished, up to 255 pending
// - Nothing pending means transmit wait returns immediately
// - Start reports transmit complete, none pending
// - Transmit poll times out while frames pending
// - Stop clears queue and ends waits
package cpw_pkg;
    // ==========================================
    // Timing
    // ==========================================
    localparam int CLK_HZ = 100_000_000; // Block clock rate
    localparam int TICK_MS = 1; // Tick period in ms
    localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS; // Cycles per tick
    localparam int TMO_W = 32; // Timeout width, signed ms
    localparam int PEND_W = 8; // Pending frame counter width
    localparam logic [TMO_W-1:0] TMO_POLL = 32'h0000_0000; // Poll value
    localparam logic [TMO_W-1:0] TMO_FOREVER = 32'hffff_ffff; // Minus one
    localparam logic [PEND_W-1:0] PEND_RESET = 8'h00; // Empty queue
    // ==========================================
    // Wait engine states
    // ==========================================
    typedef enum logic [1:0] {CPW_IDLE, CPW_WAIT, CPW_DONE} cpw_state_type;
endpackage

// [hdl/cpw_wait_if.sv]
`timescale 1ns/100ps
// ==========================================
// Link between top and one wait engine
// ==========================================
interface cpw_wait_if;
    import cpw_pkg::*;
    logic start; // Wait request pulse
    logic [TMO_W-1:0] timeout; // Requested timeout, ms
    logic event_hit; // Condition met this cycle
    logic abort; // Stop ends the wait
    logic tick; // Millisecond tick
    logic done; // Result pulse
    logic timed_out; // Result flag
    logic busy; // Wait outstanding
    modport top (output start, timeout, event_hit, abort, tick, input done, timed_out, busy);
    modport eng (input start, timeout, event_hit, abort, tick, output done, timed_out, busy);
endinterface

// [hdl/cpw_wait_engine.sv]
`timescale 1ns/100ps
// ==========================================
// One wait: timeout counter and result
// ==========================================
module cpw_wait_engine (
    input wire logic clk,
    input wire logic rst_n,
    cpw_wait_if.eng w
);
    import cpw_pkg::*;
    cpw_state_type state_reg, state_next; // Engine state
    logic [TMO_W-1:0] cnt_reg, cnt_next; // Remaining ms
    logic forever_reg, forever_next; // No time limit
    logic tmo_reg, tmo_next; // Result flag
    logic expire; // Counter ran out
    assign expire = !forever_reg && (cnt_reg == TMO_POLL);
    assign w.done = (state_reg == CPW_DONE);
    assign w.timed_out = tmo_reg;
    assign w.busy = (state_reg == CPW_WAIT);
    // Next state; event checked before expiry so a zero poll sees a latched event
    always_comb begin
        state_next = state_reg;
        cnt_next = cnt_reg;
        forever_next = forever_reg;
        tmo_next = tmo_reg;
        case (state_reg)
            CPW_IDLE: begin
                if (w.start) begin
                    // Counter loaded from the request
                    cnt_next = w.timeout;
                    forever_next = (w.timeout == TMO_FOREVER);
                    state_next = CPW_WAIT;
                end
            end
            CPW_WAIT: begin
                if (w.abort) begin
                    // Stop ends the wait quietly
                    state_next = CPW_IDLE;
                end else if (w.event_hit) begin
                    tmo_next = 1'b0;
                    state_next = CPW_DONE;
                end else if (expire) begin
                    tmo_next = 1'b1;
                    state_next = CPW_DONE;
                end else if (w.tick && !forever_reg) begin
                    cnt_next = cnt_reg - 32'h0000_0001;
                end
            end
            CPW_DONE: state_next = CPW_IDLE;
            default: state_next = CPW_IDLE;
        endcase
    end
    // State registers
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_reg <= CPW_IDLE;
            cnt_reg <= TMO_POLL;
            forever_reg <= 1'b0;
            tmo_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            forever_reg <= forever_next;
            tmo_reg <= tmo_next;
        end
    end
    // ==========================================
    // Checks
    // ==========================================
    a_forever_no_tmo: assert property (@(posedge clk) disable iff (!rst_n)
        (state_reg == CPW_WAIT && forever_reg && !w.abort && !w.event_hit) |=> !(w.done && w.timed_out))
        else $error("infinite wait timed out");
    a_poll_one_step: assert property (@(posedge clk) disable iff (!rst_n)
        (state_reg == CPW_IDLE && w.start && w.timeout == TMO_POLL) |=> ##1 (w.done || state_reg == CPW_IDLE))
        else $error("poll did not finish in two cycles");
    a_abort_idle: assert property (@(posedge clk) disable iff (!rst_n)
        (state_reg == CPW_WAIT && w.abort) |=> (state_reg == CPW_IDLE && !w.done))
        else $error("stop did not end wait");
    c_timeout: cover property (@(posedge clk) disable iff (!rst_n) w.done && w.timed_out);
    c_event: cover property (@(posedge clk) disable iff (!rst_n) w.done && !w.timed_out);
endmodule

// [verif/tb_top.sv]
`timescale 1ns/100ps
// ==========================================
// Bench for the wakeup and transmit waits
// ==========================================
module tb_top;
    import cpw_pkg::*;
    // One table row: stimulus, which wait, expected flag
    typedef struct packed {
        logic [2:0] act;
        logic kind;
        logic exp_to;
    } cpw_row_type;
    logic CLK = 1'h0;
    logic RST_N = 1'h0;
    logic START_COMM = 1'h0, STOP_COMM = 1'h0, XCVR_SLEEP_IN = 1'h0, MODE_WR_NORMAL = 1'h0;
    logic TX_QUEUED = 1'h0, TX_FINISHED = 1'h0, WAKE_REQ = 1'h0, TXC_REQ = 1'h0;
    logic [TMO_W-1:0] WAKE_TIMEOUT = 32'h0, TXC_TIMEOUT = 32'h0;
    wire logic WAKE_DONE, WAKE_TIMED_OUT, WAKE_ERROR, TXC_DONE, TXC_TIMED_OUT, TXC_ERROR;
    wire logic COMM_RUNNING, TX_ALL_DONE;
    int n_fail = 0;
    int compares = 0;
    // Acts: 1 sleep, 2 local wake, 3 remote wake, 4 queue, 5 finish; all polls use timeout 0
    cpw_row_type rows [9] = '{'{3'h0, 1'h1, 1'h0}, '{3'h1, 1'h0, 1'h1}, '{3'h2, 1'h0, 1'h0},
        '{3'h0, 1'h0, 1'h1}, '{3'h3, 1'h0, 1'h0}, '{3'h4, 1'h1, 1'h1}, '{3'h4, 1'h1, 1'h1},
        '{3'h5, 1'h1, 1'h1}, '{3'h5, 1'h1, 1'h0}};
    // ==========================================
    // Clock and device
    // ==========================================
    initial begin
        forever #5 CLK = ~CLK;
    end
    cpw_top dut (.CLK(CLK), .RST_N(RST_N), .START_COMM(START_COMM), .STOP_COMM(STOP_COMM),
        .XCVR_SLEEP_IN(XCVR_SLEEP_IN), .MODE_WR_NORMAL(MODE_WR_NORMAL), .TX_QUEUED(TX_QUEUED),
        .TX_FINISHED(TX_FINISHED), .WAKE_REQ(WAKE_REQ), .WAKE_TIMEOUT(WAKE_TIMEOUT), .TXC_REQ(TXC_REQ),
        .TXC_TIMEOUT(TXC_TIMEOUT), .WAKE_DONE(WAKE_DONE), .WAKE_TIMED_OUT(WAKE_TIMED_OUT),
        .WAKE_ERROR(WAKE_ERROR), .TXC_DONE(TXC_DONE), .TXC_TIMED_OUT(TXC_TIMED_OUT),
        .TXC_ERROR(TXC_ERROR), .COMM_RUNNING(COMM_RUNNING), .TX_ALL_DONE(TX_ALL_DONE));
    // ==========================================
    // Shared tasks
    // ==========================================
    // Compare and count; four-state compare so unknowns fail
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            n_fail++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Apply one stimulus, then let the synchroniser settle
    task automatic act(input int a);
        case (a)
            1: XCVR_SLEEP_IN = 1'h1;
            2: MODE_WR_NORMAL = 1'h1;
            3: XCVR_SLEEP_IN = 1'h0;
            4: TX_QUEUED = 1'h1;
            5: TX_FINISHED = 1'h1;
            6: START_COMM = 1'h1;
            7: STOP_COMM = 1'h1;
            default: ;
        endcase
        @(posedge CLK);
        #1;
        {MODE_WR_NORMAL, TX_QUEUED, TX_FINISHED, START_COMM, STOP_COMM} = 5'h0;
        repeat (5) @(posedge CLK);
        #1;
    endtask
    // Raise a request; the following wait lowers it
    task automatic issue(input logic kind, input logic [TMO_W-1:0] tmo);
        if (kind) begin
            TXC_TIMEOUT = tmo;
            TXC_REQ = 1'h1;
        end else begin
            WAKE_TIMEOUT = tmo;
            WAKE_REQ = 1'h1;
        end
    endtask
    // Watch for a result within lim cycles; flags are only valid with done
    task automatic await(input logic kind, input int lim, input logic e_done, input logic e_to,
        input logic e_err);
        logic d;
        d = 1'h0;
        for (int i = 0; i < lim && d !== 1'h1; i++) begin
            @(posedge CLK);
            #1;
            WAKE_REQ = 1'h0;
            TXC_REQ = 1'h0;
            MODE_WR_NORMAL = 1'h0;
            d = kind ? TXC_DONE : WAKE_DONE;
        end
        chk(d, e_done);
        if (e_done) begin
            chk(kind ? TXC_TIMED_OUT : WAKE_TIMED_OUT, e_to);
            chk(kind ? TXC_ERROR : WAKE_ERROR, e_err);
            @(posedge CLK);
            #1;
        end
    endtask
    // Single exit point for pass, fail and timeout
    task automatic end_of_test();
        $display("Comparisons %0d, mismatches %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // ==========================================
    // Watchdog, sized for one 1 ms timeout plus margin
    // ==========================================
    initial begin
        #(150000 * 10);
        n_fail++;
        end_of_test();
    end
    // ==========================================
    // Main sequence
    // ==========================================
    initial begin
        repeat (2) @(posedge CLK);
        #1;
        chk({COMM_RUNNING, WAKE_DONE, TXC_DONE, TX_ALL_DONE}, 4'h1);
        RST_N = 1'h1;
        // A wakeup request while stopped gives an error at once
        issue(1'h0, TMO_POLL);
        await(1'h0, 10, 1'h1, 1'h0, 1'h1);
        act(6);
        chk({COMM_RUNNING, TX_ALL_DONE}, 2'h3);
        // Table of ordinary polls
        foreach (rows[r]) begin
            act(rows[r].act);
            issue(rows[r].kind, TMO_POLL);
            await(rows[r].kind, 10, 1'h1, rows[r].exp_to, 1'h0);
        end
        // Unlimited wakeup wait ended by a local wake
        act(1);
        issue(1'h0, TMO_FOREVER);
        await(1'h0, 30, 1'h0, 1'h0, 1'h0);
        // Local wake raised by hand so the one-cycle result is watched while it stands
        MODE_WR_NORMAL = 1'h1;
        await(1'h0, 20, 1'h1, 1'h0, 1'h0);
        // One millisecond timeout: flag set, no error
        issue(1'h0, 32'h1);
        await(1'h0, 100010, 1'h1, 1'h1, 1'h0);
        // Stop during an unlimited transmit wait: no result, queue cleared
        act(4);
        chk(TX_ALL_DONE, 1'h0);
        issue(1'h1, TMO_FOREVER);
        await(1'h1, 20, 1'h0, 1'h0, 1'h0);
        act(7);
        await(1'h1, 20, 1'h0, 1'h0, 1'h0);
        chk({COMM_RUNNING, TX_ALL_DONE}, 2'h1);
        issue(1'h1, TMO_POLL);
        await(1'h1, 10, 1'h1, 1'h0, 1'h1);
        // Wake and queue while stopped leave nothing behind after start
        act(2);
        act(4);
        act(6);
        chk(TX_ALL_DONE, 1'h1);
        issue(1'h0, TMO_POLL);
        await(1'h0, 10, 1'h1, 1'h1, 1'h0);
        issue(1'h1, TMO_POLL);
        await(1'h1, 10, 1'h1, 1'h0, 1'h0);
        // Reset in mid-run returns to the stopped, empty state
        act(4);
        RST_N = 1'h0;
        repeat (2) @(posedge CLK);
        #1;
        chk({COMM_RUNNING, TX_ALL_DONE}, 2'h1);
        // Released again: stopped, so a request errors at once
        RST_N = 1'h1;
        issue(1'h1, TMO_POLL);
        await(1'h1, 10, 1'h1, 1'h0, 1'h1);
        end_of_test();
    end
endmodule
